// file: src/spis_defines.svh
// Register offsets, field positions and fixed values of the SPI slave
// semaphore block. Assumes 12-bit byte addresses on the register bus.
`ifndef SPIS_DEFINES_SVH
`define SPIS_DEFINES_SVH

`define OFS_ACQ      12'h024
`define OFS_REL      12'h028
`define OFS_SUB_ACQ  12'h0a4
`define OFS_SUB_REL  12'h0a8
`define OFS_EV_END   12'h104
`define OFS_EV_RX    12'h110
`define OFS_EV_ACQ   12'h128
`define OFS_PUB_END  12'h184
`define OFS_PUB_RX   12'h190
`define OFS_PUB_ACQ  12'h1a8
`define OFS_EVENT_TASK_LINKS   12'h200
`define OFS_MASKSET  12'h304
`define OFS_MASKCLR  12'h308
`define OFS_SEM_OWN  12'h400
`define OFS_STATUS   12'h440
`define OFS_UNIT     12'h500
`define OFS_PSCK     12'h508
`define OFS_PMISO    12'h50c
`define OFS_PMOSI    12'h510
`define OFS_PCSN     12'h514
`define OFS_RXPTR    12'h534
`define OFS_RXMAX    12'h538
`define OFS_RXAMT    12'h53c
`define OFS_RXLIST   12'h540
`define OFS_TXPTR    12'h544
`define OFS_TXMAX    12'h548
`define OFS_TXAMT    12'h54c
`define OFS_TXLIST   12'h550
`define OFS_CONFIG   12'h554
`define OFS_IGN_CHR  12'h55c
`define OFS_OVR_CHR  12'h5c0
// Byte buffer windows, 16 words each, selected by address bits 11:6
`define RXWIN_IDX    6'h18
`define TXWIN_IDX    6'h19

`define CH_MSB       3
`define EN_BIT       31
`define DISC_BIT     31
`define SC_END_ACQ   2
`define IB_END       1
`define IB_RX        4
`define IB_ACQ       10
`define ST_OVR       0
`define ST_OVF       1
`define CFG_LSB      0
`define CFG_CPHA     1
`define CFG_CPOL     2
`define UNIT_ON_VAL  4'h2
`define RESP_OKAY    2'b00
`define RESP_DECERR  2'b11

`endif

// file: src/spis_pkg.sv
// Types of the SPI slave semaphore block: bus carriers and module state.
// Assumes the AXI4-Lite master drives 12-bit addresses.
`default_nettype none
package spis_pkg;

  typedef enum logic [1:0] {
    SEM_FREE     = 2'b00,
    SEM_CPU      = 2'b01,
    SEM_SLV      = 2'b10,
    SEM_CPU_WAIT = 2'b11
  } sem_e;

  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;

  typedef struct packed {
    axi_rsp_s          rsp;
    logic              aw_h;
    logic              w_h;
    logic [11:0]       wa;
    logic [31:0]       wd;
    logic [3:0]        ws;
    sem_e              sem;
    logic [31:0]       sub_acq;
    logic [31:0]       sub_rel;
    logic [31:0]       pub_end;
    logic [31:0]       pub_rx;
    logic [31:0]       pub_acq;
    logic              ev_end;
    logic              ev_rx;
    logic              ev_acq;
    logic              sc_end_acq;
    logic [2:0]        mask;
    logic              ovr;
    logic              ovf;
    logic [3:0]        unit;
    logic [31:0]       psel_sck;
    logic [31:0]       psel_miso;
    logic [31:0]       psel_mosi;
    logic [31:0]       psel_cs;
    logic [31:0]       rx_base;
    logic [31:0]       tx_base;
    logic [7:0]        rx_lim;
    logic [7:0]        tx_lim;
    logic [7:0]        rx_amt;
    logic [7:0]        tx_amt;
    logic [7:0]        rx_cnt;
    logic [7:0]        tx_cnt;
    logic [1:0]        rx_list;
    logic [1:0]        tx_list;
    logic [2:0]        cfg;
    logic [7:0]        dfl;
    logic [7:0]        ovr_fill;
    logic [15:0][7:0]  rxm;
    logic [15:0][7:0]  txm;
    logic [2:0]        sck_s;
    logic [1:0]        mosi_s;
    logic [1:0]        cs_sync;
    logic              busy;
    logic              grant;
    logic [2:0]        bitn;
    logic [7:0]        rsh;
    logic [7:0]        tsh;
    logic              reload;
    logic              miso;
    logic              miso_oe;
    logic              irq;
    logic [15:0]       evt_out;
  } state_s;

endpackage
`default_nettype wire

// file: src/spis_sem_regs.sv
// SPI slave with a buffer semaphore, AXI4-Lite registers and 16-byte
// receive and transmit buffers. Assumes SCK, MOSI and chip select come
// from pins in another clock domain; EVT_IN comes from REF_CLK logic.
//
// Overview of operation
// - Release task hands semaphore from CPU to free
// - Acquire by task write or subscribed event
// - Release also triggerable by subscribed event
// - Ignored transaction shifts out default character
// - Received byte count latched after granted transaction
// - Sent byte count latched after granted transaction
// - Store no more than receive limit
// - Fetch no more than transmit limit
// - Receive-full flag set and published
// - Transaction-done flag set and published
// - Semaphore-granted flag set and published
// - Shortcut lets done event trigger acquire
// - Error status and semaphore state readable
// - Pin routes; alias names share offsets
// - Enable gives CPU semaphore without event
// - Simultaneous request at start goes to CPU
// - Chip select rise releases and signals done
// - Excess reads flag error, send overrun char
`include "spis_defines.svh"
`default_nettype none
module spis_sem_regs (
  input  wire logic               REF_CLK,
  input  wire logic               RST_N,
  input  wire spis_pkg::axi_req_s AXI_REQ,
  output var  spis_pkg::axi_rsp_s AXI_RSP,
  input  wire logic               SCK,
  input  wire logic               MOSI,
  input  wire logic               CHIP_SELECT_N,
  output var  logic               MISO_O,
  output var  logic               MISO_OE,
  input  wire logic [15:0]        EVT_IN,
  output var  logic [15:0]        EVT_OUT,
  output var  logic               IRQ
);

  spis_pkg::state_s q;
  spis_pkg::state_s n;
  logic [33:0] rq;
  logic [31:0] wv;
  logic        wr;
  logic        en;
  logic        sel;
  logic        start;
  logic        stop;
  logic        lead;
  logic        trail;
  logic        samp;
  logic        shft;
  logic        acq_req;
  logic        rel_req;
  logic        g_now;
  logic        load_now;
  logic        g_use;
  logic [7:0]  cnt_use;
  logic        ev_end_p;
  logic        ev_rx_p;
  logic        ev_acq_p;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] d,
                                      input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction

  // Address decode shared by reads and writes: {resp, data}
  function automatic logic [33:0] rd(input logic [11:0] a, input spis_pkg::state_s s);
    logic [31:0] d;
    logic        ok;
    d = 32'h0;
    ok = 1'b1;
    if (a == `OFS_ACQ || a == `OFS_REL) d = 32'h0;
    else if (a == `OFS_SUB_ACQ) d = s.sub_acq;
    else if (a == `OFS_SUB_REL) d = s.sub_rel;
    else if (a == `OFS_EV_END) d[0] = s.ev_end;
    else if (a == `OFS_EV_RX) d[0] = s.ev_rx;
    else if (a == `OFS_EV_ACQ) d[0] = s.ev_acq;
    else if (a == `OFS_PUB_END) d = s.pub_end;
    else if (a == `OFS_PUB_RX) d = s.pub_rx;
    else if (a == `OFS_PUB_ACQ) d = s.pub_acq;
    else if (a == `OFS_EVENT_TASK_LINKS) d[`SC_END_ACQ] = s.sc_end_acq;
    else if (a == `OFS_MASKSET || a == `OFS_MASKCLR)
    begin
      d[`IB_END] = s.mask[0];
      d[`IB_RX] = s.mask[1];
      d[`IB_ACQ] = s.mask[2];
    end
    else if (a == `OFS_SEM_OWN) d[1:0] = s.sem;
    else if (a == `OFS_STATUS)
    begin
      d[`ST_OVR] = s.ovr;
      d[`ST_OVF] = s.ovf;
    end
    else if (a == `OFS_UNIT) d[3:0] = s.unit;
    else if (a == `OFS_PSCK) d = s.psel_sck;
    else if (a == `OFS_PMISO) d = s.psel_miso;
    else if (a == `OFS_PMOSI) d = s.psel_mosi;
    else if (a == `OFS_PCSN) d = s.psel_cs;
    else if (a == `OFS_RXPTR) d = s.rx_base;
    else if (a == `OFS_RXMAX) d[7:0] = s.rx_lim;
    else if (a == `OFS_RXAMT) d[7:0] = s.rx_amt;
    else if (a == `OFS_RXLIST) d[1:0] = s.rx_list;
    else if (a == `OFS_TXPTR) d = s.tx_base;
    else if (a == `OFS_TXMAX) d[7:0] = s.tx_lim;
    else if (a == `OFS_TXAMT) d[7:0] = s.tx_amt;
    else if (a == `OFS_TXLIST) d[1:0] = s.tx_list;
    else if (a == `OFS_CONFIG) d[2:0] = s.cfg;
    else if (a == `OFS_IGN_CHR) d[7:0] = s.dfl;
    else if (a == `OFS_OVR_CHR) d[7:0] = s.ovr_fill;
    else if (a[11:6] == `RXWIN_IDX) d[7:0] = s.rxm[a[5:2]];
    else if (a[11:6] == `TXWIN_IDX) d[7:0] = s.txm[a[5:2]];
    else ok = 1'b0;
    return {ok ? `RESP_OKAY : `RESP_DECERR, d};
  endfunction

  // Next state of the whole block
  always_comb
  begin
    n = q;
    ev_end_p = 1'b0;
    ev_rx_p = 1'b0;
    ev_acq_p = 1'b0;
    acq_req = 1'b0;
    rel_req = 1'b0;

    // Pin synchronisers; the second stage is looked at, and SCK edges also use the third
    n.sck_s = {q.sck_s[1:0], SCK};
    n.mosi_s = {q.mosi_s[0], MOSI};
    n.cs_sync = {q.cs_sync[0], CHIP_SELECT_N};
    en = (q.unit == `UNIT_ON_VAL);
    // A disconnected input route keeps the slave deselected
    sel = en & ~q.psel_sck[`DISC_BIT] & ~q.psel_mosi[`DISC_BIT]
          & ~q.psel_cs[`DISC_BIT] & ~q.cs_sync[1];
    start = sel & ~q.busy;
    stop = q.busy & ~sel;
    lead = (q.sck_s[1] ^ q.cfg[`CFG_CPOL]) & ~(q.sck_s[2] ^ q.cfg[`CFG_CPOL]);
    trail = ~(q.sck_s[1] ^ q.cfg[`CFG_CPOL]) & (q.sck_s[2] ^ q.cfg[`CFG_CPOL]);
    samp = q.busy & (q.cfg[`CFG_CPHA] ? trail : lead);
    shft = q.busy & (q.cfg[`CFG_CPHA] ? lead : trail);
    n.busy = sel;

    // AXI4-Lite channels; a write lands once address and data are both held
    if (AXI_REQ.awvalid && q.rsp.awready)
    begin
      n.aw_h = 1'b1;
      n.wa = {AXI_REQ.awaddr[11:2], 2'b00};
    end
    if (AXI_REQ.wvalid && q.rsp.wready)
    begin
      n.w_h = 1'b1;
      n.wd = AXI_REQ.wdata;
      n.ws = AXI_REQ.wstrb;
    end
    if (q.rsp.bvalid && AXI_REQ.bready) n.rsp.bvalid = 1'b0;
    rq = rd(q.wa, q);
    wr = q.aw_h & q.w_h & ~q.rsp.bvalid;
    wv = mrg(32'h0, q.wd, q.ws);
    if (wr)
    begin
      n.aw_h = 1'b0;
      n.w_h = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = rq[33:32];
    end
    n.rsp.awready = ~n.aw_h;
    n.rsp.wready = ~n.w_h;
    if (q.rsp.rvalid && AXI_REQ.rready) n.rsp.rvalid = 1'b0;
    if (AXI_REQ.arvalid && q.rsp.arready)
    begin
      n.rsp.rvalid = 1'b1;
      {n.rsp.rresp, n.rsp.rdata} = rd({AXI_REQ.araddr[11:2], 2'b00}, q);
    end
    n.rsp.arready = ~n.rsp.rvalid;

    // Register writes; unmapped and read-only words are ignored
    if (wr && rq[33:32] == `RESP_OKAY)
    begin
      if (q.wa == `OFS_ACQ) acq_req = wv[0];
      else if (q.wa == `OFS_REL) rel_req = wv[0];
      else if (q.wa == `OFS_SUB_ACQ) n.sub_acq = mrg(q.sub_acq, q.wd, q.ws);
      else if (q.wa == `OFS_SUB_REL) n.sub_rel = mrg(q.sub_rel, q.wd, q.ws);
      else if (q.wa == `OFS_EV_END && q.ws[0]) n.ev_end = q.wd[0];
      else if (q.wa == `OFS_EV_RX && q.ws[0]) n.ev_rx = q.wd[0];
      else if (q.wa == `OFS_EV_ACQ && q.ws[0]) n.ev_acq = q.wd[0];
      else if (q.wa == `OFS_PUB_END) n.pub_end = mrg(q.pub_end, q.wd, q.ws);
      else if (q.wa == `OFS_PUB_RX) n.pub_rx = mrg(q.pub_rx, q.wd, q.ws);
      else if (q.wa == `OFS_PUB_ACQ) n.pub_acq = mrg(q.pub_acq, q.wd, q.ws);
      else if (q.wa == `OFS_EVENT_TASK_LINKS && q.ws[0]) n.sc_end_acq = q.wd[`SC_END_ACQ];
      else if (q.wa == `OFS_MASKSET)
        n.mask = q.mask | {wv[`IB_ACQ], wv[`IB_RX], wv[`IB_END]};
      else if (q.wa == `OFS_MASKCLR)
        n.mask = q.mask & ~{wv[`IB_ACQ], wv[`IB_RX], wv[`IB_END]};
      else if (q.wa == `OFS_STATUS)
      begin
        n.ovr = q.ovr & ~wv[`ST_OVR];
        n.ovf = q.ovf & ~wv[`ST_OVF];
      end
      else if (q.wa == `OFS_UNIT && q.ws[0]) n.unit = q.wd[3:0];
      else if (q.wa == `OFS_PSCK) n.psel_sck = mrg(q.psel_sck, q.wd, q.ws);
      else if (q.wa == `OFS_PMISO) n.psel_miso = mrg(q.psel_miso, q.wd, q.ws);
      else if (q.wa == `OFS_PMOSI) n.psel_mosi = mrg(q.psel_mosi, q.wd, q.ws);
      else if (q.wa == `OFS_PCSN) n.psel_cs = mrg(q.psel_cs, q.wd, q.ws);
      else if (q.wa == `OFS_RXPTR) n.rx_base = mrg(q.rx_base, q.wd, q.ws);
      else if (q.wa == `OFS_RXMAX && q.ws[0]) n.rx_lim = q.wd[7:0];
      else if (q.wa == `OFS_RXLIST && q.ws[0]) n.rx_list = q.wd[1:0];
      else if (q.wa == `OFS_TXPTR) n.tx_base = mrg(q.tx_base, q.wd, q.ws);
      else if (q.wa == `OFS_TXMAX && q.ws[0]) n.tx_lim = q.wd[7:0];
      else if (q.wa == `OFS_TXLIST && q.ws[0]) n.tx_list = q.wd[1:0];
      else if (q.wa == `OFS_CONFIG && q.ws[0]) n.cfg = q.wd[2:0];
      else if (q.wa == `OFS_IGN_CHR && q.ws[0]) n.dfl = q.wd[7:0];
      else if (q.wa == `OFS_OVR_CHR && q.ws[0]) n.ovr_fill = q.wd[7:0];
      else if (q.wa[11:6] == `TXWIN_IDX && q.ws[0]) n.txm[q.wa[5:2]] = q.wd[7:0];
    end

    // Subscribed interconnect channels trigger the tasks too
    if (q.sub_acq[`EN_BIT] && EVT_IN[q.sub_acq[`CH_MSB:0]]) acq_req = 1'b1;
    if (q.sub_rel[`EN_BIT] && EVT_IN[q.sub_rel[`CH_MSB:0]]) rel_req = 1'b1;

    // Semaphore; held by the CPU while disabled so enabling raises no event
    g_now = 1'b0;
    if (!en)
    begin
      n.sem = spis_pkg::SEM_CPU;
      n.grant = 1'b0;
    end
    else if (stop && q.grant)
    begin
      ev_end_p = 1'b1;
      n.grant = 1'b0;
      n.rx_amt = q.rx_cnt;
      n.tx_amt = q.tx_cnt;
      // A waiting request and the shortcut are served once together
      if (q.sem == spis_pkg::SEM_CPU_WAIT || acq_req || q.sc_end_acq)
      begin
        n.sem = spis_pkg::SEM_CPU;
        ev_acq_p = 1'b1;
      end
      else n.sem = spis_pkg::SEM_FREE;
    end
    else
    begin
      case (q.sem)
        spis_pkg::SEM_FREE:
          if (acq_req)
          begin
            n.sem = spis_pkg::SEM_CPU;
            ev_acq_p = 1'b1;
          end
          else if (start)
          begin
            n.sem = spis_pkg::SEM_SLV;
            n.grant = 1'b1;
            g_now = 1'b1;
          end
        spis_pkg::SEM_CPU:
          if (acq_req) ev_acq_p = 1'b1;
          else if (rel_req) n.sem = spis_pkg::SEM_FREE;
        spis_pkg::SEM_SLV:
          if (acq_req) n.sem = spis_pkg::SEM_CPU_WAIT;
        default: n.sem = q.sem;
      endcase
    end

    // Transmit byte selection at start (mode with early data) or reload
    if (start)
    begin
      n.bitn = 3'h0;
      n.rx_cnt = 8'h0;
      n.tx_cnt = 8'h0;
      n.reload = q.cfg[`CFG_CPHA];
    end
    load_now = start ? ~q.cfg[`CFG_CPHA] : (shft & q.reload);
    g_use = start ? g_now : q.grant;
    cnt_use = start ? 8'h0 : q.tx_cnt;
    if (load_now)
    begin
      n.reload = 1'b0;
      if (!g_use) n.tsh = q.dfl;
      else if (cnt_use < q.tx_lim)
      begin
        n.tsh = q.txm[4'(q.tx_base[3:0] + cnt_use[3:0])];
        n.tx_cnt = cnt_use + 8'h1;
      end
      else
      begin
        n.tsh = q.ovr_fill;
        n.ovr = 1'b1;
      end
    end
    else if (shft)
      n.tsh = q.cfg[`CFG_LSB] ? {1'b0, q.tsh[7:1]} : {q.tsh[6:0], 1'b0};

    // Receive shift; a whole byte goes to the buffer only when granted
    if (samp)
    begin
      n.rsh = q.cfg[`CFG_LSB] ? {q.mosi_s[1], q.rsh[7:1]} : {q.rsh[6:0], q.mosi_s[1]};
      n.bitn = q.bitn + 3'h1;
      if (q.bitn == 3'h7)
      begin
        n.reload = 1'b1;
        if (q.grant && q.rx_cnt < q.rx_lim)
        begin
          n.rxm[4'(q.rx_base[3:0] + q.rx_cnt[3:0])] = n.rsh;
          n.rx_cnt = q.rx_cnt + 8'h1;
          if (q.rx_cnt + 8'h1 == q.rx_lim) ev_rx_p = 1'b1;
        end
        else if (q.grant) n.ovf = 1'b1;
      end
    end

    // Pin outputs; the output bit follows the shift register
    n.miso = q.cfg[`CFG_LSB] ? n.tsh[0] : n.tsh[7];
    n.miso_oe = n.busy & ~q.psel_miso[`DISC_BIT];

    // Hardware sets win over a software clear in the same cycle
    n.ev_end = n.ev_end | ev_end_p;
    n.ev_rx = n.ev_rx | ev_rx_p;
    n.ev_acq = n.ev_acq | ev_acq_p;
    n.evt_out = 16'h0;
    if (ev_end_p && q.pub_end[`EN_BIT]) n.evt_out[q.pub_end[`CH_MSB:0]] = 1'b1;
    if (ev_rx_p && q.pub_rx[`EN_BIT]) n.evt_out[q.pub_rx[`CH_MSB:0]] = 1'b1;
    if (ev_acq_p && q.pub_acq[`EN_BIT]) n.evt_out[q.pub_acq[`CH_MSB:0]] = 1'b1;
    n.irq = |({n.ev_acq, n.ev_rx, n.ev_end} & n.mask);
  end

  // State register
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N) q <= '0;
    else q <= n;
  end

  // Outputs straight from the state register
  assign AXI_RSP = q.rsp;
  assign MISO_O = q.miso;
  assign MISO_OE = q.miso_oe;
  assign EVT_OUT = q.evt_out;
  assign IRQ = q.irq;

  // Checks on semaphore, counts and events
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  chk_rel_frees: assert property (
    en && q.sem == spis_pkg::SEM_CPU && rel_req && !acq_req && !stop
    |=> q.sem == spis_pkg::SEM_FREE) else $error("release did not free");
  chk_sub_acq_hits: assert property (
    en && q.sem inside {spis_pkg::SEM_FREE, spis_pkg::SEM_CPU} && q.sub_acq[`EN_BIT]
    && EVT_IN[q.sub_acq[`CH_MSB:0]] |=> q.ev_acq) else $error("subscribed acquire lost");
  chk_ignored_def: assert property (
    load_now && !g_use |=> q.tsh == $past(q.dfl)) else $error("default char missing");
  chk_amounts: assert property (
    stop && q.grant && en |=> q.rx_amt == $past(q.rx_cnt) && q.tx_amt == $past(q.tx_cnt))
    else $error("amounts not latched");
  chk_rx_bound: assert property (
    q.grant && $stable(q.rx_lim) |-> q.rx_cnt <= q.rx_lim) else $error("rx over limit");
  chk_tx_bound: assert property (
    q.grant && $stable(q.tx_lim) |-> q.tx_cnt <= q.tx_lim) else $error("tx over limit");
  chk_rx_publish: assert property (
    ev_rx_p && q.pub_rx[`EN_BIT] |=> q.ev_rx && q.evt_out[$past(q.pub_rx[3:0])])
    else $error("rx full not published");
  chk_race_cpu: assert property (
    start && q.sem == spis_pkg::SEM_FREE && acq_req
    |=> q.sem == spis_pkg::SEM_CPU && !q.grant ##1 !q.grant) else $error("race lost by cpu");
  chk_end_frees: assert property (
    en && stop && q.grant |=> q.ev_end && !q.grant && q.sem inside
    {spis_pkg::SEM_FREE, spis_pkg::SEM_CPU}) else $error("end not handled");
  chk_tx_excess_error: assert property (
    load_now && g_use && cnt_use >= q.tx_lim |=> q.ovr && q.tsh == $past(q.ovr_fill))
    else $error("tx_excess_error not flagged");
  chk_enable_quiet: assert property (
    !en ##1 en |-> q.sem == spis_pkg::SEM_CPU && !ev_acq_p) else $error("enable raised event");

  cov_granted: cover property (start ##[1:300] stop && q.grant);
  cov_ignored: cover property (start && !g_now ##[1:300] stop);
  cov_wait_handover: cover property (q.sem == spis_pkg::SEM_CPU_WAIT ##[1:300] ev_acq_p);
  cov_overflow: cover property ($rose(q.ovf));

endmodule
`default_nettype wire

// file: verif/spi_master_model.sv
// SPI master model for the slave bench: mode 0, MSB first.
// Assumes frame() is called from one procedural thread at a time.
`default_nettype none
module spi_master_model (
  output var  logic SCK,
  output var  logic MOSI,
  output var  logic CHIP_SELECT_N,
  input  wire logic MISO
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: deselected, clock low
  initial
  begin
    SCK = 1'b0;
    MOSI = 1'b0;
    CHIP_SELECT_N = 1'b1;
  end

  // One frame of n bytes; SCK period 200 ns, clock still outside frames
  task automatic frame(input int n, input logic [3:0][7:0] tx, output logic [3:0][7:0] rx);
    rx = '0;
    // Step off the clock edge at which the caller returns, so no pin races it
    #1;
    CHIP_SELECT_N = 1'b0;
    #207;
    for (int i = 0; i < n; i++)
      for (int b = 7; b >= 0; b--)
      begin
        MOSI = tx[i][b];
        #100;
        SCK = 1'b1;
        rx[i][b] = MISO;
        #100;
        SCK = 1'b0;
      end
    #200;
    CHIP_SELECT_N = 1'b1;
    // Released line shows a changed level, never the stale bit
    MOSI = ~MOSI;
    #400;
  endtask
endmodule
`default_nettype wire

// file: verif/test_spis_sem_regs.sv
// Bench for the SPI slave semaphore block: AXI4-Lite tasks, SPI master.
// Assumes the register map of spis_defines.svh and 16-byte buffers.
`include "spis_defines.svh"
`default_nettype none
module test_spis_sem_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic               ref_clk;
  logic               rst_n;
  spis_pkg::axi_req_s req;
  spis_pkg::axi_rsp_s rsp;
  logic               sck;
  logic               mosi;
  logic               cs_n;
  logic               miso_o;
  logic               miso_oe;
  wire  logic         miso_w;
  logic [15:0]        evt_in;
  logic [15:0]        evt_out;
  logic               irq;
  int                 error_cnt;
  int                 checks_done;
  int                 pub_cnt [16];

  // Undriven MISO floats, so a missing enable fails the compare
  assign miso_w = miso_oe ? miso_o : 1'bz;

  spis_sem_regs u_dut (.REF_CLK(ref_clk), .RST_N(rst_n), .AXI_REQ(req), .AXI_RSP(rsp),
    .SCK(sck), .MOSI(mosi), .CHIP_SELECT_N(cs_n), .MISO_O(miso_o), .MISO_OE(miso_oe),
    .EVT_IN(evt_in), .EVT_OUT(evt_out), .IRQ(irq));
  spi_master_model u_master (.SCK(sck), .MOSI(mosi), .CHIP_SELECT_N(cs_n), .MISO(miso_w));

  // 40 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Count published pulses per channel
  always @(posedge ref_clk)
    for (int i = 0; i < 16; i++)
      if (evt_out[i] === 1'b1)
        pub_cnt[i]++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 200)
    begin
      error_cnt++;
      complete_run();
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    int   n;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    // Start one edge clear of the last release, never in its time step
    @(posedge ref_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (aw && rsp.awready)
      begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready)
      begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end while (!rsp.bvalid && n < 200);
    r = rsp.bresp;
    req.bready <= 1'b0;
    tmo(n);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar;
    int   n;
    ar = 1'b1;
    n = 0;
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (ar && rsp.arready)
      begin
        ar = 1'b0;
        req.arvalid <= 1'b0;
      end
    end while (!rsp.rvalid && n < 200);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    tmo(n);
  endtask

  task automatic w(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(d, e);
  endtask

  // One-cycle pulse on an interconnect channel
  task automatic pulse(input int ch);
    evt_in <= 16'h0001 << ch;
    @(posedge ref_clk);
    evt_in <= 16'h0000;
  endtask

  // Main sequence
  initial
  begin
    logic [3:0][7:0] rxb;
    logic [31:0]     d;
    logic [1:0]      r;
    req = '0;
    evt_in = '0;
    rst_n = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rc(`OFS_SEM_OWN, 32'h00000001);
    rd(12'h7fc, d, r);
    check({30'h0, r}, 32'h00000003);
    wr(12'h7fc, 32'h00000001, r);
    check({30'h0, r}, 32'h00000003);
    for (int i = 0; i < 4; i++)
    begin
      w(`OFS_PSCK + 12'(4 * i), 32'h80000010 + i);
      rc(`OFS_PSCK + 12'(4 * i), 32'h80000010 + i);
      w(`OFS_PSCK + 12'(4 * i), 32'h00000000);
    end
    w(`OFS_RXAMT, 32'h000000ff);
    rc(`OFS_RXAMT, 32'h00000000);
    $display("test decode done");
    w(`OFS_UNIT, 32'h00000002);
    rc(`OFS_SEM_OWN, 32'h00000001);
    rc(`OFS_EV_ACQ, 32'h00000000);
    w(`OFS_ACQ, 32'h00000000);
    rc(`OFS_EV_ACQ, 32'h00000000);
    w(`OFS_ACQ, 32'h00000001);
    rc(`OFS_EV_ACQ, 32'h00000001);
    w(`OFS_EV_ACQ, 32'h00000000);
    rc(`OFS_EV_ACQ, 32'h00000000);
    $display("test enable done");
    w(`OFS_IGN_CHR, 32'h000000a5);
    u_master.frame(2, 32'h0000c33c, rxb);
    check({16'h0, rxb[1:0]}, 32'h0000a5a5);
    rc(`OFS_EV_END, 32'h00000000);
    rc(`OFS_TXAMT, 32'h00000000);
    $display("test ignored done");
    w(`OFS_REL, 32'h00000001);
    rc(`OFS_SEM_OWN, 32'h00000000);
    w(12'h640, 32'h44332211);
    w(12'h644, 32'h00000022);
    w(`OFS_RXMAX, 32'h00000002);
    w(`OFS_TXMAX, 32'h00000002);
    w(`OFS_OVR_CHR, 32'h0000005a);
    w(`OFS_PUB_END, 32'h80000003);
    w(`OFS_PUB_RX, 32'h80000004);
    w(`OFS_MASKSET, 32'h00000002);
    u_master.frame(3, 32'h00184281, rxb);
    check({8'h0, rxb[2:0]}, 32'h005a2211);
    rc(`OFS_EV_END, 32'h00000001);
    rc(`OFS_SEM_OWN, 32'h00000000);
    rc(`OFS_RXAMT, 32'h00000002);
    rc(`OFS_TXAMT, 32'h00000002);
    rc(`OFS_EV_RX, 32'h00000001);
    rc(`OFS_STATUS, 32'h00000003);
    rc(12'h600, 32'h00000081);
    rc(12'h604, 32'h00000042);
    rc(12'h608, 32'h00000000);
    check(pub_cnt[3], 32'h00000001);
    check(pub_cnt[4], 32'h00000001);
    w(`OFS_STATUS, 32'h00000003);
    rc(`OFS_STATUS, 32'h00000000);
    w(`OFS_MASKSET, 32'h00000000);
    repeat (2) @(posedge ref_clk);
    check({31'h0, irq}, 32'h00000001);
    w(`OFS_MASKCLR, 32'h00000002);
    repeat (2) @(posedge ref_clk);
    check({31'h0, irq}, 32'h00000000);
    $display("test granted done");
    w(`OFS_SUB_ACQ, 32'h80000005);
    w(`OFS_SUB_REL, 32'h80000006);
    w(`OFS_PUB_ACQ, 32'h80000007);
    pulse(5);
    rc(`OFS_SEM_OWN, 32'h00000001);
    rc(`OFS_EV_ACQ, 32'h00000001);
    check(pub_cnt[7], 32'h00000001);
    pulse(6);
    rc(`OFS_SEM_OWN, 32'h00000000);
    $display("test events done");
    // Subscribed acquire lands in the cycle the slave first sees select
    fork
      u_master.frame(1, 32'h000000f0, rxb);
      begin
        repeat (2) @(posedge ref_clk);
        pulse(5);
      end
    join
    check({24'h0, rxb[0]}, 32'h000000a5);
    rc(`OFS_SEM_OWN, 32'h00000001);
    w(`OFS_REL, 32'h00000001);
    $display("test race done");
    w(`OFS_EVENT_TASK_LINKS, 32'h00000004);
    w(`OFS_EV_ACQ, 32'h00000000);
    // LSB first on the slave, so the MSB-first master sees bits reversed
    w(`OFS_CONFIG, 32'h00000001);
    u_master.frame(1, 32'h000000f0, rxb);
    check({24'h0, rxb[0]}, 32'h00000088);
    rc(12'h600, 32'h0000000f);
    rc(`OFS_SEM_OWN, 32'h00000001);
    rc(`OFS_EV_ACQ, 32'h00000001);
    check(pub_cnt[3], 32'h00000002);
    $display("test shortcut done");
    complete_run();
  end
endmodule
`default_nettype wire
